// [hdl/phrase_playback_sequencer.sv]
// Summary of operation
// - Class D forces gain code to zero dB
// - Two-byte launch waits gap, then second byte
// - Final byte, lookup, fetch lead, then phrase_launch_cmd
// - Ready low while preparing, high at start
// - Busy low for fetch plus sound length
// - Start needs one byte, behaves like launch
// - Faded halt holds busy per rate group
// - Silence: fetch lead, then phrase_launch_cmd silence
// - Launch holds command busy until playback prepared
// - Queued item keeps ready low until start
// - Busy stays low across whole chain
// - Repeat set honoured only while playing
// - Repeat mode holds ready low
// - Wide launch: gap after each early byte
// - Reset behaves same in every state
// - Commands framed as one, two, three bytes
// - Fade bit picks abrupt or faded halt
`timescale 1ns/10ps
`default_nettype none
module phrase_playback_sequencer #(
  parameter int TICK_CYC = (seq_pkg::TICK_TIME_US * seq_pkg::NS_PER_US) / seq_pkg::CLK_PERIOD_NS,
  parameter int FADE_G0_CYC = (seq_pkg::FADE_G0_TIME_US * seq_pkg::NS_PER_US) / seq_pkg::CLK_PERIOD_NS,
  parameter int FADE_G1_CYC = (seq_pkg::FADE_G1_TIME_US * seq_pkg::NS_PER_US) / seq_pkg::CLK_PERIOD_NS,
  parameter int FADE_G2_CYC = (seq_pkg::FADE_G2_TIME_US * seq_pkg::NS_PER_US) / seq_pkg::CLK_PERIOD_NS,
  parameter int FADE_G3_CYC = (seq_pkg::FADE_G3_TIME_US * seq_pkg::NS_PER_US) / seq_pkg::CLK_PERIOD_NS,
  parameter int FADE_G4_CYC = (seq_pkg::FADE_G4_TIME_US * seq_pkg::NS_PER_US) / seq_pkg::CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Serial command port
  input  wire logic                     csb_n,
  input  wire logic                     sck,
  input  wire logic                     si,
  // Status pins
  output logic                          cmd_busy_n,
  output logic [seq_pkg::NCH-1:0]       channel_busy_n,
  output logic [seq_pkg::NCH-1:0]       next_cmd_ready
);
  import seq_pkg::*;

  // Length of a command in bytes, zero for unknown codes
  function automatic logic [1:0] cmd_len(input logic [7:0] b);
    logic [1:0] n;
    n = 2'd0;
    case (b[7:4])
      OP_ADDR_SET, OP_LAUNCH, OP_SILENCE, OP_CH_GAIN: n = 2'd2;
      OP_START, OP_HALT, OP_REP_SET, OP_REP_CLEAR:    n = 2'd1;
      default: n = 2'd0;
    endcase
    if (b[7:2] == OP_MODE_HI) n = 2'd2;
    case (b)
      OP_POWER_UP0, OP_POWER_UP1, OP_WDOG_CLR, OP_POWER_DN, OP_ERR_CLR: n = 2'd1;
      OP_ANALOG_GN, OP_FADE_SET, OP_DIRECT, OP_STATUS_RD, OP_VER_RD,
      OP_ERR_RD, OP_OUT_SEL, OP_SAFETY: n = 2'd2;
      OP_WIDE_ADDR, OP_WIDE_LNCH: n = 2'd3;
      default: ;
    endcase
    return n;
  endfunction : cmd_len

  // Channel mask from a command byte of the given kind
  function automatic logic [NCH-1:0] ch_mask(input logic [7:0] b, input logic [3:0] op,
                                             input logic strobe);
    return (strobe && b[7:4] == op) ? b[NCH-1:0] : '0;
  endfunction : ch_mask

  localparam logic [CNT_W-1:0] GAP_LOAD   = CNT_W'(BYTE_GAP_CYC);
  localparam logic [CNT_W-1:0] FETCH_LOAD = CNT_W'(FETCH_LEAD_CYC);
  localparam logic [CNT_W-1:0] TICK_LAST  = CNT_W'(TICK_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ONE    = CNT_W'(1);
  localparam logic [LEN_W-1:0] LEN_ONE    = LEN_W'(1);

  // Input synchronisers
  logic csb_m_q, csb_s_q, sck_m_q, sck_s_q, sck_d_q, si_m_q, si_s_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {csb_m_q, csb_s_q} <= 2'b11;
      {sck_m_q, sck_s_q, sck_d_q} <= 3'b000;
      {si_m_q, si_s_q} <= 2'b00;
    end else begin
      {csb_m_q, csb_s_q} <= {csb_n, csb_m_q};
      {sck_m_q, sck_s_q, sck_d_q} <= {sck, sck_m_q, sck_s_q};
      {si_m_q, si_s_q} <= {si, si_m_q};
    end
  end

  // Byte assembly, MSB first on rising clock
  logic [7:0] shift_q;
  logic [2:0] bit_q;
  logic       byte_v_q;
  wire        sck_rise = sck_s_q & ~sck_d_q;
  wire  [7:0] shift_nx = {shift_q[6:0], si_s_q};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q  <= 8'h00;
      bit_q    <= 3'h0;
      byte_v_q <= 1'b0;
    end else begin
      byte_v_q <= csb_s_q ? 1'b0 : (sck_rise && bit_q == 3'h7);
      if (csb_s_q) begin
        bit_q <= 3'h0;
      end else if (sck_rise) begin
        shift_q <= shift_nx;
        bit_q   <= bit_q + 3'h1;
      end
    end
  end

  // Command parser
  parse_state_t      pst_q;
  logic [CNT_W-1:0]  gap_q;
  logic [1:0]        need_q, got_q;
  logic [7:0]        b0_q, b1_q;
  logic [PHRASE_W-1:0] phrase_q;
  logic [1:0]        chan_q;
  logic [1:0]        pipe_q;
  logic              pipe_launch_q;
  logic              amp_class_select, fade_on_halt_bit, hpf_q;
  logic [3:0]        gain_q;
  logic [2:0]        fs_group_q;
  logic [LEN_W-1:0]  mem_rdata;
  logic [LEN_W-1:0]  set_len_q [NCH];
  logic [NCH-1:0]    qv_q, rep_q, phrase_launch_cmd_q;
  logic [CNT_W-1:0]  prep_q [NCH];

  wire       take     = byte_v_q && (pst_q == P_IDLE || pst_q == P_NEXT);
  wire [1:0] first_n  = cmd_len(shift_q);
  wire       first    = take && pst_q == P_IDLE;
  wire       final_b  = take && (first ? first_n == 2'd1 : got_q + 2'd1 == need_q);
  wire [7:0] op_b     = first ? shift_q : b0_q;
  wire       is_wide  = op_b == OP_WIDE_LNCH || op_b == OP_WIDE_ADDR;
  wire       is_lnch  = op_b == OP_WIDE_LNCH || (!is_wide && op_b[7:4] == OP_LAUNCH);
  wire       is_aset  = op_b == OP_WIDE_ADDR || (!is_wide && op_b[7:4] == OP_ADDR_SET);
  wire [PHRASE_W-1:0] phr_nx = is_wide ? {b1_q[3:0], shift_q} : {2'b00, b0_q[3:2], shift_q};
  wire [1:0] chan_nx  = is_wide ? b1_q[5:4] : b0_q[1:0];
  wire       one_b    = final_b && first;
  wire [NCH-1:0] start_m = ch_mask(shift_q, OP_START, one_b);
  wire [NCH-1:0] halt_m  = ch_mask(shift_q, OP_HALT, one_b);
  wire [NCH-1:0] rset_m  = ch_mask(shift_q, OP_REP_SET, one_b);
  wire [NCH-1:0] rclr_m  = ch_mask(shift_q, OP_REP_CLEAR, one_b);
  wire [NCH-1:0] sil_m   = ch_mask(b0_q, OP_SILENCE, final_b && !first);
  wire       apply    = pipe_q[1];
  wire       fetch_done = pipe_q == 2'b00 && !(qv_q[chan_q] && prep_q[chan_q] != '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pst_q <= P_IDLE;
      gap_q <= '0;
      need_q <= 2'd0;
      got_q <= 2'd0;
      b0_q <= 8'h00;
      b1_q <= 8'h00;
      phrase_q <= '0;
      chan_q <= 2'd0;
      pipe_q <= 2'b00;
      pipe_launch_q <= 1'b0;
      amp_class_select <= 1'b0;
      fade_on_halt_bit <= 1'b0;
      hpf_q <= 1'b0;
      gain_q <= 4'h0;
    end else begin
      pipe_q <= {pipe_q[0], final_b && (is_lnch || is_aset)};
      if (take) begin
        got_q <= first ? 2'd1 : got_q + 2'd1;
        if (first) begin
          b0_q <= shift_q;
          need_q <= first_n;
        end else begin
          b1_q <= shift_q;
        end
      end
      if (final_b && (is_lnch || is_aset)) begin
        phrase_q <= phr_nx;
        chan_q <= chan_nx;
        pipe_launch_q <= is_lnch;
      end
      if (final_b && !first && b0_q[7:2] == OP_MODE_HI) begin
        amp_class_select <= b0_q[MODE_AMP_BIT];
        hpf_q <= b0_q[MODE_HPF_BIT];
        fade_on_halt_bit <= shift_q[MODE_FADE_BIT];
      end
      if (final_b && !first && b0_q == OP_ANALOG_GN) begin
        gain_q <= shift_q[GAIN_LSB +: 4];
      end
      case (pst_q)
        P_IDLE, P_NEXT: begin
          if (take && first && first_n == 2'd0) begin
            pst_q <= P_IDLE;
          end else if (final_b && is_lnch) begin
            pst_q <= P_FETCH;
            gap_q <= FETCH_LOAD;
          end else if (take) begin
            pst_q <= P_GAP;
            gap_q <= GAP_LOAD;
          end
        end
        P_GAP: begin
          gap_q <= gap_q - CNT_ONE;
          if (gap_q == CNT_ONE) begin
            pst_q <= (got_q == need_q) ? P_IDLE : P_NEXT;
          end
        end
        P_FETCH: begin
          if (gap_q != '0) gap_q <= gap_q - CNT_ONE;
          if (fetch_done && gap_q == '0) begin
            pst_q <= P_IDLE;
          end
        end
        default: pst_q <= P_IDLE;
      endcase
    end
  end

  // Per-channel playback
  logic [NCH-1:0]   busy_n_q, rdy_q;
  logic [LEN_W-1:0] pcnt_q [NCH];
  logic [LEN_W-1:0] qlen_q [NCH];
  logic [LEN_W-1:0] cur_q  [NCH];
  logic [CNT_W-1:0] fade_q [NCH];
  logic [CNT_W-1:0] tick_q;
  wire              tick = tick_q == TICK_LAST;
  wire [NCH-1:0]    can_take = ~qv_q & ~rep_q;
  wire [CNT_W-1:0]  fade_load =
      fs_group_q == 3'd0 ? CNT_W'(FADE_G0_CYC) :
      fs_group_q == 3'd1 ? CNT_W'(FADE_G1_CYC) :
      fs_group_q == 3'd2 ? CNT_W'(FADE_G2_CYC) :
      fs_group_q == 3'd3 ? CNT_W'(FADE_G3_CYC) : CNT_W'(FADE_G4_CYC);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick ? '0 : tick_q + CNT_ONE;
    end
  end

  // one reset path for all states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_n_q <= '1;
      rdy_q    <= '1;
      qv_q     <= '0;
      rep_q    <= '0;
      phrase_launch_cmd_q   <= '0;
      for (int i = 0; i < NCH; i++) begin
        pcnt_q[i] <= '0;
        qlen_q[i] <= '0;
        cur_q[i]  <= '0;
        fade_q[i] <= '0;
        prep_q[i] <= '0;
        set_len_q[i] <= '0;
      end
    end else begin
      rdy_q <= can_take;
      for (int i = 0; i < NCH; i++) begin
        if (apply && !pipe_launch_q && chan_q == 2'(i)) begin
          set_len_q[i] <= mem_rdata;
        end
        if (halt_m[i]) begin
          qv_q[i]   <= 1'b0;
          rep_q[i]  <= 1'b0;
          phrase_launch_cmd_q[i] <= 1'b0;
          prep_q[i] <= '0;
          if (fade_on_halt_bit && phrase_launch_cmd_q[i]) begin
            fade_q[i] <= fade_load;
          end else begin
            busy_n_q[i] <= 1'b1;
          end
        end else begin
          if (fade_q[i] != '0) begin
            fade_q[i] <= fade_q[i] - CNT_ONE;
            if (fade_q[i] == CNT_ONE) busy_n_q[i] <= 1'b1;
          end
          if (prep_q[i] != '0) prep_q[i] <= prep_q[i] - CNT_ONE;
          if (can_take[i] && fade_q[i] == '0 &&
              ((apply && pipe_launch_q && chan_q == 2'(i)) || start_m[i] || sil_m[i])) begin
            qv_q[i]     <= 1'b1;
            prep_q[i]   <= FETCH_LOAD;
            busy_n_q[i] <= 1'b0;
            qlen_q[i]   <= sil_m[i] ? LEN_W'(shift_q) :
                           start_m[i] ? set_len_q[i] : mem_rdata;
          end
          if (qv_q[i] && prep_q[i] == '0 && !phrase_launch_cmd_q[i]) begin
            phrase_launch_cmd_q[i] <= 1'b1;
            pcnt_q[i] <= qlen_q[i];
            cur_q[i]  <= qlen_q[i];
            qv_q[i]   <= 1'b0;
          end
          if (phrase_launch_cmd_q[i] && tick) begin
            if (pcnt_q[i] > LEN_ONE) begin
              pcnt_q[i] <= pcnt_q[i] - LEN_ONE;
            end else if (rep_q[i]) begin
              pcnt_q[i] <= cur_q[i];
            end else if (qv_q[i] && prep_q[i] == '0) begin
              pcnt_q[i] <= qlen_q[i];
              cur_q[i]  <= qlen_q[i];
              qv_q[i]   <= 1'b0;
            end else begin
              phrase_launch_cmd_q[i] <= 1'b0;
              if (!qv_q[i]) busy_n_q[i] <= 1'b1;
            end
          end
          if (rset_m[i] && phrase_launch_cmd_q[i]) rep_q[i] <= 1'b1;
          if (rclr_m[i]) rep_q[i] <= 1'b0;
        end
      end
    end
  end

  // APB decode
  wire        setup    = psel & ~penable;
  wire        wr_acc   = psel & penable & pwrite;
  wire        tbl_we   = wr_acc && paddr == ADDR_TABLE;
  wire        mapped   = paddr == ADDR_CTRL || paddr == ADDR_STATUS ||
                         paddr == ADDR_AUDIO || paddr == ADDR_TABLE;

  phrase_len_mem u_mem (
    .pclk  (pclk),
    .we    (tbl_we),
    .waddr (pwdata[TBL_PHR_LSB +: PHRASE_W]),
    .wdata (pwdata[LEN_W-1:0]),
    .raddr (phrase_q),
    .rdata (mem_rdata)
  );

  wire [3:0]  eff_gain = amp_class_select ? GAIN_0DB_CODE : gain_q;
  wire [31:0] rd_ctrl  = {29'h0, fs_group_q};
  wire [31:0] rd_stat  = {19'h0, cmd_busy_n, rep_q, rdy_q, busy_n_q};
  wire [31:0] rd_audio = {24'h0, eff_gain, 1'b0, hpf_q, fade_on_halt_bit, amp_class_select};
  wire [31:0] rd_mux   = paddr == ADDR_CTRL   ? rd_ctrl :
                         paddr == ADDR_STATUS ? rd_stat :
                         paddr == ADDR_AUDIO  ? rd_audio : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      fs_group_q <= CTRL_RESET;
      cmd_busy_n <= 1'b1;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup && !pwrite) prdata <= rd_mux;
      if (wr_acc && paddr == ADDR_CTRL) fs_group_q <= pwdata[2:0];
      cmd_busy_n <= pst_q == P_IDLE || pst_q == P_NEXT;
    end
  end

  assign channel_busy_n = busy_n_q;
  assign next_cmd_ready = rdy_q;
endmodule : phrase_playback_sequencer
`default_nettype wire

// [hdl/seq_pkg.sv]
package seq_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS      = 50;
  localparam int BYTE_GAP_TIME_NS   = 20000;
  localparam int FETCH_LEAD_TIME_NS = 50000;
  localparam int BYTE_GAP_CYC       = (BYTE_GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FETCH_LEAD_CYC     = (FETCH_LEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FADE_G0_TIME_US    = 3000;
  localparam int FADE_G1_TIME_US    = 5000;
  localparam int FADE_G2_TIME_US    = 4000;
  localparam int FADE_G3_TIME_US    = 2900;
  localparam int FADE_G4_TIME_US    = 2700;
  localparam int TICK_TIME_US       = 1000;
  localparam int NS_PER_US          = 1000;
  localparam int CNT_W              = 17;

  // Channels and phrase table
  localparam int NCH       = 4;
  localparam int PHRASE_W  = 12;
  localparam int LEN_W     = 16;
  localparam int DEPTH     = 4096;

  // Command byte codes
  localparam logic [3:0] OP_ADDR_SET   = 4'h3;
  localparam logic [3:0] OP_LAUNCH     = 4'h4;
  localparam logic [3:0] OP_START      = 4'h5;
  localparam logic [3:0] OP_HALT       = 4'h6;
  localparam logic [3:0] OP_SILENCE    = 4'h7;
  localparam logic [3:0] OP_REP_SET    = 4'h8;
  localparam logic [3:0] OP_REP_CLEAR  = 4'h9;
  localparam logic [3:0] OP_CH_GAIN    = 4'ha;
  localparam logic [5:0] OP_MODE_HI    = 6'h01;
  localparam logic [7:0] OP_POWER_UP0  = 8'h00;
  localparam logic [7:0] OP_POWER_UP1  = 8'h01;
  localparam logic [7:0] OP_ANALOG_GN  = 8'h08;
  localparam logic [7:0] OP_FADE_SET   = 8'h0c;
  localparam logic [7:0] OP_DIRECT     = 8'h10;
  localparam logic [7:0] OP_WDOG_CLR   = 8'h14;
  localparam logic [7:0] OP_POWER_DN   = 8'h20;
  localparam logic [7:0] OP_STATUS_RD  = 8'hb0;
  localparam logic [7:0] OP_VER_RD     = 8'hb4;
  localparam logic [7:0] OP_ERR_RD     = 8'hb8;
  localparam logic [7:0] OP_OUT_SEL    = 8'hc0;
  localparam logic [7:0] OP_WIDE_ADDR  = 8'hc4;
  localparam logic [7:0] OP_WIDE_LNCH  = 8'hc8;
  localparam logic [7:0] OP_SAFETY     = 8'hd0;
  localparam logic [7:0] OP_ERR_CLR    = 8'hff;

  // Mode and gain byte fields
  localparam int MODE_AMP_BIT  = 1;
  localparam int MODE_HPF_BIT  = 0;
  localparam int MODE_FADE_BIT = 7;
  localparam int GAIN_LSB      = 2;
  localparam logic [3:0] GAIN_0DB_CODE = 4'hf;

  // APB map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_AUDIO  = 8'h08;
  localparam logic [7:0] ADDR_TABLE  = 8'h0c;
  localparam int ST_READY_LSB  = 4;
  localparam int ST_REP_LSB    = 8;
  localparam int ST_CBUSY_BIT  = 12;
  localparam int AU_FADE_BIT   = 1;
  localparam int AU_HPF_BIT    = 2;
  localparam int AU_GAIN_LSB   = 4;
  localparam int TBL_PHR_LSB   = 16;
  localparam logic [2:0] CTRL_RESET = 3'h2;

  typedef enum logic [1:0] {P_IDLE, P_GAP, P_NEXT, P_FETCH} parse_state_t;
endpackage : seq_pkg

// [hdl/phrase_len_mem.sv]
`timescale 1ns/10ps
`default_nettype none
module phrase_len_mem (
  // Clock
  input  wire logic                          pclk,
  // Write port
  input  wire logic                          we,
  input  wire logic [seq_pkg::PHRASE_W-1:0]  waddr,
  input  wire logic [seq_pkg::LEN_W-1:0]     wdata,
  // Read port
  input  wire logic [seq_pkg::PHRASE_W-1:0]  raddr,
  output logic      [seq_pkg::LEN_W-1:0]     rdata
);
  import seq_pkg::*;

  logic [LEN_W-1:0] mem [DEPTH];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : phrase_len_mem
`default_nettype wire

// [testbench/phrase_playback_sequencer_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module phrase_playback_sequencer_assertions (
  // Clock and reset
  input wire logic                    pclk,
  input wire logic                    presetn,
  // APB handshake
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pready,
  input wire logic                    pslverr,
  // Status pins
  input wire logic                    cmd_busy_n,
  input wire logic [seq_pkg::NCH-1:0] channel_busy_n,
  input wire logic [seq_pkg::NCH-1:0] next_cmd_ready
);
  import seq_pkg::*;
  localparam int GAP_MIN   = BYTE_GAP_CYC - 1;
  localparam int FETCH_MIN = FETCH_LEAD_CYC - 10;
  logic [15:0] cb_low_q;
  logic [15:0] ch_low_q;
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Length of the current low stretch of cmd_busy_n and of channel_busy_n[0]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cb_low_q <= 16'h0000;
      ch_low_q <= 16'h0000;
    end else begin
      cb_low_q <= cmd_busy_n ? 16'h0000 : cb_low_q + 16'h0001;
      ch_low_q <= channel_busy_n[0] ? 16'h0000 : ch_low_q + 16'h0001;
    end
  end
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside access cycle");
  reset_idle_a: assert property ($rose(presetn) |->
    cmd_busy_n && (&channel_busy_n) && (&next_cmd_ready))
    else $error("status pins not idle after reset");
  byte_gap_a: assert property ($rose(cmd_busy_n) |-> cb_low_q >= GAP_MIN)
    else $error("command busy released too early");
  prep_ready_a: assert property ($fell(channel_busy_n[0]) |->
    ##2 !next_cmd_ready[0] [*8])
    else $error("ready high while preparing");
  busy_span_a: assert property ($rose(channel_busy_n[0]) |-> ch_low_q >= FETCH_MIN)
    else $error("channel busy shorter than fetch lead");
  fetch_lead_a: assert property ($rose(next_cmd_ready[0]) && !channel_busy_n[0] |->
    ch_low_q >= FETCH_MIN)
    else $error("playback started before fetch lead");
  cmd_release_a: assert property ($rose(next_cmd_ready[0]) && cb_low_q > 16'h01f4 |->
    ##[0:2] cmd_busy_n)
    else $error("command busy not released at playback start");
  cover property ($rose(channel_busy_n[0]));
  cover property (pslverr);
  cover property ($rose(next_cmd_ready[1]) && !channel_busy_n[1]);
endmodule : phrase_playback_sequencer_assertions

bind phrase_playback_sequencer phrase_playback_sequencer_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .cmd_busy_n(cmd_busy_n), .channel_busy_n(channel_busy_n),
  .next_cmd_ready(next_cmd_ready)
);
`default_nettype wire

// [testbench/serial_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
  // Clock
  input  wire logic pclk,
  // Device status
  input  wire logic cmd_busy_n,
  // Serial command port
  output var  logic csb_n,
  output var  logic sck,
  output var  logic si
);
  initial begin
    csb_n = 1'b1;
    sck   = 1'b0;
    si    = 1'b0;
  end
  // Link clock at 400 ns, still between frames
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    while (cmd_busy_n !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    csb_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      si <= b[i];
      repeat (4) @(posedge pclk);
      sck <= 1'b1;
      repeat (4) @(posedge pclk);
      sck <= 1'b0;
    end
    repeat (4) @(posedge pclk);
    csb_n <= 1'b1;
    si    <= ~b[0];
  endtask : send
endmodule : serial_host_model
`default_nettype wire

// [testbench/phrase_playback_sequencer_test.sv]
`timescale 1ns/10ps
`default_nettype none
module phrase_playback_sequencer_test;
  import seq_pkg::*;
  localparam int FADE0 = 30;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        csb_n;
  logic        sck;
  logic        si;
  logic        cmd_busy_n;
  logic [3:0]  channel_busy_n;
  logic [3:0]  next_cmd_ready;
  int          mismatches = 0;
  int          num_checks = 0;
  int          n;

  always #25 pclk = ~pclk;

  phrase_playback_sequencer #(
    .TICK_CYC    (10),
    .FADE_G0_CYC (FADE0),
    .FADE_G1_CYC (50),
    .FADE_G2_CYC (40),
    .FADE_G3_CYC (29),
    .FADE_G4_CYC (27)
  ) u_dut (
    .pclk           (pclk),
    .presetn        (presetn),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .csb_n          (csb_n),
    .sck            (sck),
    .si             (si),
    .cmd_busy_n     (cmd_busy_n),
    .channel_busy_n (channel_busy_n),
    .next_cmd_ready (next_cmd_ready)
  );

  serial_host_model u_host (
    .pclk       (pclk),
    .cmd_busy_n (cmd_busy_n),
    .csb_n      (csb_n),
    .sck        (sck),
    .si         (si)
  );

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk4(input string what, input logic [3:0] exp, input logic [3:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk4

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Wait states until pready, ended only by the watchdog
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so the next call never re-drives in this time step
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk("prdata", exp, r);
    chk("pslverr", {31'h0, err}, {31'h0, e});
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  // Bounded wait for a channel pin: busy when sel, ready otherwise
  task automatic wt(input int ch, input logic sel, input logic lvl, output int k);
    k = 0;
    while ((sel ? channel_busy_n[ch] : next_cmd_ready[ch]) !== lvl && k < 4000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 4000) mismatches++;
  endtask : wt

  task automatic span(input int ch);
    int k;
    wt(ch, 1'b1, 1'b0, k);
    wt(ch, 1'b1, 1'b1, k);
    chk("busy span", 32'h1, 32'(k >= FETCH_LEAD_CYC + 10 && k <= FETCH_LEAD_CYC + 45));
  endtask : span

  task automatic done(input string name);
    $display("TEST %s finished", name);
  endtask : done

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    #3_000_000;
    mismatches++;
    close_out();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk4("busy", 4'hf, channel_busy_n);
    chk4("ready", 4'hf, next_cmd_ready);
    rd(ADDR_STATUS, 32'h0000_10ff, 1'b0);
    rd(ADDR_CTRL, 32'(CTRL_RESET), 1'b0);
    rd(8'h10, 32'h0000_0000, 1'b1);
    wr(ADDR_TABLE, {4'h0, 12'h005, 16'h0003});
    wr(ADDR_TABLE, {4'h0, 12'h006, 16'h00c8});
    rd(ADDR_TABLE, 32'h0000_0000, 1'b0);
    done("reset and map");
    u_host.send({OP_LAUNCH, 4'h0});
    u_host.send(8'h05);
    wt(0, 1'b1, 1'b0, n);
    repeat (2) @(posedge pclk);
    chk4("ready", 4'he, next_cmd_ready);
    wt(0, 1'b0, 1'b1, n);
    chk("fetch", 32'h1, 32'(n >= FETCH_LEAD_CYC - 25 && n <= FETCH_LEAD_CYC + 5));
    wt(0, 1'b1, 1'b1, n);
    chk("sound", 32'h1, 32'(n >= 15 && n <= 45));
    done("launch");
    u_host.send({OP_LAUNCH, 4'h1});
    u_host.send(8'h06);
    wt(1, 1'b0, 1'b1, n);
    u_host.send({OP_SILENCE, 4'h2});
    u_host.send(8'h64);
    chk4("ready", 4'hd, next_cmd_ready);
    chk4("busy", 4'hd, channel_busy_n);
    wt(1, 1'b0, 1'b1, n);
    chk4("busy", 4'hd, channel_busy_n);
    u_host.send({OP_LAUNCH, 4'h1});
    u_host.send(8'h05);
    chk4("ready", 4'hd, next_cmd_ready);
    wt(1, 1'b0, 1'b1, n);
    chk4("busy", 4'hd, channel_busy_n);
    wt(1, 1'b1, 1'b1, n);
    done("chain");
    u_host.send({OP_ADDR_SET, 4'h2});
    u_host.send(8'h05);
    u_host.send({OP_START, 4'h4});
    span(2);
    u_host.send(OP_WIDE_LNCH);
    u_host.send(8'h30);
    u_host.send(8'h05);
    span(3);
    done("start and wide");
    wr(ADDR_CTRL, 32'h0000_0000);
    rd(ADDR_CTRL, 32'h0000_0000, 1'b0);
    u_host.send({OP_MODE_HI, 2'b10});
    u_host.send(8'h80);
    u_host.send(OP_ANALOG_GN);
    u_host.send(8'h14);
    repeat (4) @(posedge pclk);
    rd(ADDR_AUDIO, {24'h0, GAIN_0DB_CODE, 4'h3}, 1'b0);
    u_host.send({OP_MODE_HI, 2'b00});
    u_host.send(8'h80);
    repeat (4) @(posedge pclk);
    rd(ADDR_AUDIO, {24'h0, 4'h5, 4'h2}, 1'b0);
    u_host.send({OP_LAUNCH, 4'h0});
    u_host.send(8'h06);
    wt(0, 1'b0, 1'b1, n);
    u_host.send({OP_REP_SET, 4'h1});
    repeat (4) @(posedge pclk);
    chk4("ready", 4'he, next_cmd_ready);
    rd(ADDR_STATUS, 32'h0000_01ee, 1'b0);
    u_host.send({OP_LAUNCH, 4'h0});
    u_host.send(8'h05);
    chk4("busy", 4'he, channel_busy_n);
    u_host.send({OP_HALT, 4'h1});
    wt(0, 1'b1, 1'b1, n);
    chk("fade", 32'h1, 32'(n >= FADE0 - 12 && n <= FADE0 + 5));
    done("repeat and halt");
    u_host.send({OP_LAUNCH, 4'h0});
    u_host.send(8'h06);
    wt(0, 1'b1, 1'b0, n);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk4("busy", 4'hf, channel_busy_n);
    chk4("ready", 4'hf, next_cmd_ready);
    rd(ADDR_STATUS, 32'h0000_10ff, 1'b0);
    rd(ADDR_CTRL, 32'(CTRL_RESET), 1'b0);
    done("reset in run");
    close_out();
  end
endmodule : phrase_playback_sequencer_test
`default_nettype wire
